// ==== hdl/cgp_decim.sv ====
// Purpose: Decimating box-car filter for the modulator bitstream.
// Assumes: samp_en marks each modulator sample; dens_bit is synced.
// Notes:   Emits one signed sum of 64 bipolar samples per window.
`timescale 1ns/1ns
`include "cgp_regs.svh"

module cgp_decim (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             clr,
  input  wire logic             samp_en,
  input  wire logic             dens_bit,
  // Decimated output
  output cgp_pkg::cgp_dec_t     dec
);
  import cgp_pkg::*;

  logic        [5:0] cnt_q;
  logic signed [7:0] sum_q;
  logic signed [7:0] step;
  logic signed [7:0] sum_d;
  logic              win_end;
  cgp_dec_t          dec_q;

  // Each sample counts +1 for a one and -1 for a zero
  assign step    = dens_bit ? 8'sh01 : 8'shff;
  assign sum_d   = sum_q + step;
  assign win_end = samp_en && (cnt_q == `CGP_DEC_LAST);
  assign dec     = dec_q;

  // Window accumulator; clr drops a partly filled window
  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      cnt_q <= 6'h00;
      sum_q <= 8'sh00;
      dec_q <= '0;
    end else begin
      dec_q.valid <= win_end; // R1
      if (win_end) begin
        dec_q.sum <= sum_d; // R1
      end
      if (samp_en) begin
        cnt_q <= cnt_q + 6'h01;
        sum_q <= win_end ? 8'sh00 : sum_d;
      end
    end
  end

endmodule : cgp_decim

// ==== hdl/cgp_gauge.sv ====
// Purpose: Current gauge back end: filter, slot average, PWM out.
// Assumes: mod_bit and power_down_n arrive from outside the clock.
// Notes:   One PWM period is exactly one averaging slot.
`timescale 1ns/1ns
`include "cgp_regs.svh"

module cgp_gauge #(
  parameter int unsigned      SLOT_CYC = `CGP_SLOT_CYC,
  parameter cgp_pkg::cgp_fs_t FS_OPT   = cgp_pkg::CGP_FS_1A
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Modulator and shutdown inputs
  input  wire logic mod_bit,
  input  wire logic power_down_n,
  // Duty-cycle output
  output logic      current_pwm
);
  import cgp_pkg::*;

  // Cycle counts derived from the slot length
  // Short levels take one sample a clock and the map shift drops by the
  // same power of two, so any power-of-two level length maps alike.
  localparam int unsigned LEVEL_CYC = SLOT_CYC / `CGP_LEVELS;
  localparam int unsigned SAMP_PER_LVL = (LEVEL_CYC >= `CGP_DEC_LEN) ?
                                         `CGP_DEC_LEN : LEVEL_CYC;
  localparam int unsigned SAMP_CYC  = LEVEL_CYC / SAMP_PER_LVL;
  localparam int unsigned MAP_SHIFT = `CGP_GAIN_SHIFT
                                      - $clog2(`CGP_DEC_LEN / SAMP_PER_LVL);
  localparam int unsigned HALF_CYC  = LEVEL_CYC / 2;
  localparam logic [15:0] LEVEL_LAST = 16'(LEVEL_CYC - 1);
  localparam logic [15:0] SAMP_LAST  = 16'(SAMP_CYC - 1);
  localparam logic [15:0] HALF_LIM   = 16'(HALF_CYC);
  localparam logic [6:0]  DEC_CNT    = 7'(SAMP_PER_LVL);

  // Full-scale option only sets the analog gain; the digital map
  // from density to duty is the same for both builds.
  localparam cgp_fs_t FS_BUILD = FS_OPT; // R7

  // Average in sample units to ramp level, clamped to the ramp
  function automatic logic [9:0] cgp_to_level(
    input logic signed [17:0] a
  );
    logic signed [31:0] p;
    logic signed [31:0] n;
    p = 32'(a) * `CGP_GAIN;
    n = (p >>> MAP_SHIFT) + `CGP_MID_S;
    if (n < 32'sh0) begin
      cgp_to_level = 10'h000;
    end else if (n > `CGP_TOP_S) begin
      cgp_to_level = `CGP_RAMP_TOP;
    end else begin
      cgp_to_level = n[9:0];
    end
  endfunction : cgp_to_level

  logic [2:0]         bit_sync_q;
  logic [2:0]         pd_sync_q;
  logic               bit_q;
  logic               pd_q;
  cgp_state_t         st_q;
  cgp_state_t         st_d;
  logic [15:0]        sub_q;
  logic [15:0]        samp_q;
  logic [6:0]         nsamp_q;
  logic [9:0]         ramp_q;
  logic signed [17:0] acc_q;
  logic [9:0]         duty_q;
  logic               slot_end_q;
  logic               pwm_q;
  cgp_dec_t           dec;

  logic               run;
  logic               level_end;
  logic               slot_end;
  logic               samp_tick;
  logic signed [17:0] acc_sum;
  logic               above;
  logic               half_hi;
  logic               pwm_d;

  // Three-stage synchronisers; a change counts once the last two agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_sync_q <= 3'h0;
      pd_sync_q  <= 3'h0;
    end else begin
      bit_sync_q <= {bit_sync_q[1:0], mod_bit};
      pd_sync_q  <= {pd_sync_q[1:0], power_down_n};
    end
  end

  // Filtered levels; power-down reads as asserted until seen high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_q <= 1'b0;
      pd_q  <= 1'b0;
    end else begin
      if (bit_sync_q[1] == bit_sync_q[2]) begin
        bit_q <= bit_sync_q[2];
      end
      if (pd_sync_q[1] == pd_sync_q[2]) begin
        pd_q <= pd_sync_q[2];
      end
    end
  end

  // Control state: off until power-down releases, first slot, run
  always_comb begin
    st_d = st_q;
    case (st_q)
      CGP_ST_OFF: begin
        if (pd_q) begin
          st_d = CGP_ST_FIRST; // R10
        end
      end
      CGP_ST_FIRST: begin
        if (!pd_q) begin
          st_d = CGP_ST_OFF; // R10
        end else if (slot_end) begin
          st_d = CGP_ST_RUN;
        end
      end
      CGP_ST_RUN: begin
        if (!pd_q) begin
          st_d = CGP_ST_OFF; // R10
        end
      end
      default: begin
        st_d = CGP_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= CGP_ST_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  // Timing strobes; samples fill the front of each level window
  assign run       = (st_q != CGP_ST_OFF);
  assign level_end = (sub_q == LEVEL_LAST);
  assign slot_end  = level_end && (ramp_q == `CGP_RAMP_TOP); // R9
  assign samp_tick = run && (samp_q == SAMP_LAST)
                     && (nsamp_q < DEC_CNT);

  // Level sub-counter and free-running ramp, held clear in shutdown
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      sub_q  <= 16'h0000; // R14
      ramp_q <= 10'h000; // R14
    end else begin
      sub_q <= level_end ? 16'h0000 : (sub_q + 16'h0001);
      if (level_end) begin
        ramp_q <= ramp_q + 10'h001; // R12
      end
    end
  end

  // Sample divider: a fixed power-of-two count per slot, so the
  // slot average needs no divider, only a constant multiply.
  always_ff @(posedge clk) begin
    if (!rst_n || !run || level_end) begin
      samp_q  <= 16'h0000;
      nsamp_q <= 7'h00;
    end else begin
      samp_q <= (samp_q == SAMP_LAST) ? 16'h0000 : (samp_q + 16'h0001);
      if (samp_tick) begin
        nsamp_q <= nsamp_q + 7'h01;
      end
    end
  end

  // Decimating filter, cleared whenever the block is off
  cgp_decim u_decim (
    .clk      (clk),
    .rst_n    (rst_n),
    .clr      (!run), // R14
    .samp_en  (samp_tick),
    .dens_bit (bit_q),
    .dec      (dec)
  ); // R1

  // Slot accumulator; a window landing on the slot edge still counts
  assign acc_sum = dec.valid ? (acc_q + 18'(dec.sum)) : acc_q;

  // Slot edge seen one clock late, so the window that closes on the
  // last sample is in before the average is taken. Ramp level 0 is
  // high for any duty, so the late load never shows on the pin.
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      slot_end_q <= 1'b0;
    end else begin
      slot_end_q <= slot_end; // R11
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      acc_q <= 18'sh00000; // R14
    end else if (slot_end_q) begin
      acc_q <= 18'sh00000; // R8
    end else begin
      acc_q <= acc_sum; // R8
    end
  end

  // Duty for the next slot; mid-scale until a full slot is in
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      duty_q <= `CGP_MID; // R3
    end else if (slot_end_q) begin
      duty_q <= cgp_to_level(acc_sum); // R11 R4 R5 R6
    end
  end

  // Compare: high while duty exceeds ramp, plus half a level
  assign above   = (duty_q > ramp_q); // R2
  assign half_hi = (duty_q == ramp_q) && (sub_q < HALF_LIM); // R13
  assign pwm_d   = run && (above || half_hi);

  // Registered output; held low in shutdown to save the load
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= pwm_d; // R10 R14
    end
  end

  assign current_pwm = pwm_q;

endmodule : cgp_gauge

// ==== hdl/cgp_pkg.sv ====
// Purpose: Types shared by the current gauge encoder files.
// Assumes: Constants live in cgp_regs.svh.
// Notes:   Types only.
package cgp_pkg;

  // Factory full-scale option, fixed at build time
  typedef enum logic {
    CGP_FS_1A = 1'b0,
    CGP_FS_2A = 1'b1
  } cgp_fs_t;

  // Control states, Gray along off -> first -> run
  typedef enum logic [1:0] {
    CGP_ST_OFF   = 2'b00,
    CGP_ST_FIRST = 2'b01,
    CGP_ST_RUN   = 2'b11
  } cgp_state_t;

  // One decimated sample of the density stream
  typedef struct packed {
    logic              valid;
    logic signed [7:0] sum;
  } cgp_dec_t;

endpackage : cgp_pkg

// ==== hdl/cgp_regs.svh ====
// Purpose: Constants for the current gauge pulse-width encoder.
// Assumes: 10 MHz system clock, one clock domain.
// Notes:   Counts are derived from times in their own units.
//
// What this block does
// [R1] Decimate modulator bitstream into multi-bit value
// [R2] Output high while measurement exceeds ramp
// [R3] Zero current gives half duty
// [R4] Positive current above half, negative below
// [R5] Full scale gives 95.5 and 4.5 percent
// [R6] Current equals 2.2 times duty minus half
// [R7] Full-scale option fixed at build time
// [R8] Average over fixed fifty millisecond slots
// [R9] One PWM period per slot, about 20 Hz
// [R10] Low power-down input forces shutdown
// [R11] Duty shows previous slot average
// [R12] Ramp uses 1024 levels per period
// [R13] Half-level extra high time each period
// [R14] Shutdown holds output; restart clears state
`ifndef CGP_REGS_SVH
`define CGP_REGS_SVH

// Clock rate and slot time in their own units
`define CGP_CLK_KHZ     10000
`define CGP_SLOT_MS     50
`define CGP_SLOT_CYC    (`CGP_SLOT_MS * `CGP_CLK_KHZ)

// Ramp and decimation shape
`define CGP_LEVELS      1024
`define CGP_RAMP_TOP    10'h3ff
`define CGP_DEC_LEN     64
`define CGP_DEC_LAST    6'h3f
`define CGP_MID         10'h200

// Level = 512 + (acc * GAIN) >> SHIFT, i.e. 1024 / 2.2 per full scale
`define CGP_GAIN        32'sh00001d17
`define CGP_GAIN_SHIFT  20
`define CGP_MID_S       32'sh00000200
`define CGP_TOP_S       32'sh000003ff

`endif

// ==== verif/cgp_duty_meter.sv ====
// Purpose: Host timer model measuring PWM high time and period.
// Assumes: Samples pwm on the system clock.
// Notes:   First capture after a restart is not meaningful.
`timescale 1ns/1ns
module cgp_duty_meter (
  // Clock and measured line
  input  wire logic        clk,
  input  wire logic        pwm,
  // Last completed period and rise count
  output logic      [31:0] hi_cnt,
  output logic      [31:0] per_cnt,
  output int               n_rise
);
  logic        last_q = 1'b0;
  logic [31:0] hi_q = 32'h0;
  logic [31:0] per_q = 32'h0;
  int          rise_q = 0;
  // One driver for the rise count the bench waits on
  assign n_rise = rise_q;
  // Capture at each rise, as an input-capture timer does
  always @(posedge clk) begin
    if (pwm && !last_q) begin
      hi_cnt <= hi_q;
      per_cnt <= per_q;
      rise_q <= rise_q + 1;
      hi_q <= 32'h1;
      per_q <= 32'h1;
    end else begin
      hi_q <= hi_q + {31'h0, pwm};
      per_q <= per_q + 32'h1;
    end
    last_q <= pwm;
  end
endmodule : cgp_duty_meter

// ==== verif/cgp_gauge_monitor.sv ====
// Purpose: Port checks for the gauge PWM output.
// Assumes: One clock; L is one ramp level in clocks.
// Notes:   Counters arm on a full period so cut periods are skipped.
`timescale 1ns/1ns
module cgp_gauge_monitor #(
  parameter int unsigned SLOT_CYC = 131072
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic mod_bit,
  input wire logic power_down_n,
  input wire logic current_pwm
);
  localparam int unsigned L = SLOT_CYC / 1024;
  logic        pwm_q, armed_q, first_q;
  logic [31:0] per_q, hi_q;
  wire         rise = current_pwm & ~pwm_q;
  wire         fall = pwm_q & ~current_pwm;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Edge counters; shutdown disarms them
  always_ff @(posedge clk) begin
    pwm_q   <= current_pwm;
    per_q   <= rise ? 32'h1 : per_q + 32'h1;
    hi_q    <= current_pwm ? hi_q + 32'h1 : 32'h0;
    armed_q <= rst_n & power_down_n & (armed_q | rise);
    first_q <= ~rst_n | ~power_down_n | (first_q & ~fall);
  end
  property p_pd_off;
    (!power_down_n)[*8] |-> !current_pwm;
  endproperty
  a_pd_off: assert property (p_pd_off)
    else $error("pwm high in shutdown");
  property p_restart;
    (!power_down_n)[*8] ##1 power_down_n |-> ##[1:12] current_pwm;
  endproperty
  a_restart: assert property (p_restart)
    else $error("no restart after shutdown");
  property p_period;
    rise && armed_q |-> per_q == 1024 * L;
  endproperty
  a_period: assert property (p_period)
    else $error("wrong period");
  property p_per_max;
    armed_q |-> per_q <= 1024 * L;
  endproperty
  a_per_max: assert property (p_per_max)
    else $error("period overrun");
  property p_half;
    fall && armed_q |-> hi_q % L == L / 2;
  endproperty
  a_half: assert property (p_half)
    else $error("high time not level plus half");
  property p_range;
    fall && armed_q |-> hi_q >= 46 * L + L / 2 && hi_q <= 977 * L + L / 2;
  endproperty
  a_range: assert property (p_range)
    else $error("duty outside full scale");
  property p_first;
    fall && armed_q && first_q |-> hi_q == 512 * L + L / 2;
  endproperty
  a_first: assert property (p_first)
    else $error("first period not mid level");
  property p_min_high;
    $rose(current_pwm) && power_down_n |-> current_pwm[*7];
  endproperty
  a_min_high: assert property (p_min_high)
    else $error("runt pulse");
  c_period: cover property (rise && armed_q);
  c_first: cover property (fall && first_q && armed_q);
  c_restart: cover property ((!power_down_n)[*8] ##1 power_down_n);
endmodule : cgp_gauge_monitor

bind cgp_gauge cgp_gauge_monitor #(.SLOT_CYC(SLOT_CYC)) i_cgp_gauge_monitor (
  .clk          (clk),
  .rst_n        (rst_n),
  .mod_bit      (mod_bit),
  .power_down_n (power_down_n),
  .current_pwm  (current_pwm)
);

// ==== verif/tb.sv ====
// Purpose: Self-checking bench for the gauge encoder.
// Assumes: Short slot of 4096 clocks, 4 clocks per level.
// Notes:   Each row needs three periods to settle one slot.
`timescale 1ns/1ns
module tb;
  import cgp_pkg::*;
  localparam int unsigned SLOT = 4096;
  localparam int unsigned L = SLOT / 1024;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        mod_bit = 1'b0;
  logic        power_down_n = 1'b1;
  logic        current_pwm;
  logic [31:0] hi_cnt, per_cnt;
  logic [8:0]  pat_hi = 9'h100;
  logic [7:0]  ph = 8'h0;
  int          n_rise;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  // Ones per 256 clocks, and the level that density must give
  logic [8:0]  row_hi [5] = '{9'h100, 9'h000, 9'h080, 9'h0c0, 9'h040};
  logic [9:0]  row_lv [5] = '{10'h3d1, 10'h02e, 10'h200, 10'h2e8, 10'h117};

  cgp_gauge #(.SLOT_CYC(SLOT), .FS_OPT(CGP_FS_1A)) i_cgp_gauge (
    .clk          (clk),
    .rst_n        (rst_n),
    .mod_bit      (mod_bit),
    .power_down_n (power_down_n),
    .current_pwm  (current_pwm)
  );
  cgp_duty_meter i_cgp_duty_meter (
    .clk     (clk),
    .pwm     (current_pwm),
    .hi_cnt  (hi_cnt),
    .per_cnt (per_cnt),
    .n_rise  (n_rise)
  );

  always #50 clk = ~clk;
  // Square density pattern; period 256 divides the slot exactly
  always @(posedge clk) begin
    ph <= ph + 8'h1;
    mod_bit <= ({1'b0, ph} < pat_hi);
    cyc = cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // Wait for n captures by the host model
  task automatic rises(input int n);
    int s;
    s = n_rise;
    wait (n_rise == s + n);
    @(negedge clk);
  endtask : rises

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    check({31'h0, current_pwm}, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    // Full-scale input, yet the first period shows mid level
    rises(2);
    check(hi_cnt, 512 * L + L / 2);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      pat_hi <= row_hi[i];
      rises(3);
      check(hi_cnt, {22'h0, row_lv[i]} * L + L / 2);
      check(per_cnt, SLOT);
    end
    // Shutdown while high: parks low, restart gives mid level
    @(posedge clk);
    pat_hi <= 9'h100;
    power_down_n <= 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    check({31'h0, current_pwm}, 32'h0);
    @(posedge clk);
    power_down_n <= 1'b1;
    rises(2);
    check(hi_cnt, 512 * L + L / 2);
    complete_run();
  end
endmodule : tb
